// *** rtl/rtc_calendar.sv ***
/*
  Calendar clock top: register port, key-sequenced write unlock, pointer
  windows onto time and alarm values, BCD calendar and timekeeper pin.
  Assumes a plain register master (one-cycle strobes, read data next cycle),
  POR_N and RESET_N synchronous to SYS_CLK, TIMEBASE_IN synchronous level.
*/
// Decided for this implementation: the address map and the strobed register port.
module rtc_calendar (
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  input wire logic POR_N,
  input wire logic TIMEBASE_IN,
  input wire logic [rtc_pkg::ADDR_W-1:0] ADDR,
  input wire logic [rtc_pkg::DATA_W-1:0] WDATA,
  input wire logic WR_STB,
  input wire logic RD_STB,
  output logic [rtc_pkg::DATA_W-1:0] RDATA,
  output logic TIMEKEEPER_OUT,
  output logic TIMEKEEPER_OE
);
  import rtc_pkg::*;

  // implemented bits of a window byte for a pointer value
  function automatic logic [7:0] field_mask(input logic [1:0] ptr, input logic high);
    logic [7:0] m;
    m = 8'h00;
    case (ptr)
      PTR_MINUTES_SECONDS_PAIR: m = high ? MIN_MASK : SEC_MASK;
      PTR_WDHR: m = high ? WDAY_MASK : HOUR_MASK;
      PTR_MTHDAY: m = high ? MON_MASK : DAY_MASK;
      default: m = high ? 8'h00 : YEAR_MASK;
    endcase
    return m;
  endfunction

  // last day of the month; every year divisible by four is leap inside 2000..2099
  function automatic logic [7:0] month_last(input logic [7:0] mon, input logic [7:0] year);
    logic leap;
    logic [7:0] d;
    leap = year[4] ? (year[3:0] == 4'h2 || year[3:0] == 4'h6)
                   : (year[3:0] == 4'h0 || year[3:0] == 4'h4 || year[3:0] == 4'h8);
    d = DAYS_31;
    case (mon)
      FEB_BCD: d = leap ? DAYS_29 : DAYS_28;
      8'h04, 8'h06, 8'h09, 8'h11: d = DAYS_30;
      default: d = DAYS_31;
    endcase
    return d;
  endfunction

  // configuration state, power-on reset only
  logic en_q;
  logic unlock_q;
  logic unlock_d;
  logic oe_q;
  logic [1:0] vptr_q;
  logic [1:0] vptr_d;
  logic [7:0] trim_q;
  // ordinary reset state
  logic alm_en_q;
  logic [1:0] aptr_q;
  logic [1:0] aptr_d;
  logic src_sel_q;
  logic [15:0] alm_q [3];
  key_state_type key_q;
  key_state_type key_d;
  logic [1:0] win_q;
  logic [1:0] win_d;
  logic alarm_level_q;
  // decode
  logic wr_cfg;
  logic wr_val_low;
  logic wr_val_high;
  logic rd_val;
  logic wr_alm_cfg;
  logic wr_alm_low;
  logic wr_alm_high;
  logic rd_alm;
  logic wr_key;
  logic wr_pin;
  logic unlock_allowed;
  logic val_low_ok;
  logic val_high_ok;
  logic [15:0] rdata_d;
  logic [7:0] val_lo;
  logic [7:0] val_hi;
  logic [15:0] alm_word;
  // time fields
  logic [7:0] sec_v;
  logic [7:0] min_v;
  logic [7:0] hour_v;
  logic [7:0] wday_v;
  logic [7:0] day_v;
  logic [7:0] mon_v;
  logic [7:0] year_v;
  logic sec_wrap;
  logic min_wrap;
  logic hour_wrap;
  logic day_wrap;
  logic mon_wrap;
  logic sec_tick;
  logic half_flag;
  logic ripple;
  logic [7:0] day_last;
  logic alarm_match;
  logic pin_level;

  assign wr_cfg = WR_STB && (ADDR == CFG_ADDR);
  assign wr_val_low = WR_STB && (ADDR == VAL_LOW_ADDR);
  assign wr_val_high = WR_STB && (ADDR == VAL_HIGH_ADDR);
  assign rd_val = RD_STB && (ADDR == VAL_LOW_ADDR || ADDR == VAL_HIGH_ADDR);
  assign wr_alm_cfg = WR_STB && (ADDR == ALM_CFG_ADDR);
  assign wr_alm_low = WR_STB && (ADDR == ALM_LOW_ADDR);
  assign wr_alm_high = WR_STB && (ADDR == ALM_HIGH_ADDR);
  assign rd_alm = RD_STB && (ADDR == ALM_LOW_ADDR || ADDR == ALM_HIGH_ADDR);
  assign wr_key = WR_STB && (ADDR == KEY_ADDR);
  assign wr_pin = WR_STB && (ADDR == PIN_CFG_ADDR);

  // unlock key sequence; any other write between the keys aborts it, except a repeated first key
  assign unlock_allowed = (key_q == KEY_OPEN);
  always_comb begin
    key_d = key_q;
    win_d = win_q;
    case (key_q)
      KEY_IDLE: begin
        if (wr_key && WDATA[7:0] == KEY_FIRST) begin
          key_d = KEY_GOT_FIRST;
        end
      end
      KEY_GOT_FIRST: begin
        if (wr_key && WDATA[7:0] == KEY_SECOND) begin
          key_d = KEY_OPEN;
          win_d = UNLOCK_WINDOW_CYC;
        end else if (wr_key && WDATA[7:0] == KEY_FIRST) begin
          key_d = KEY_GOT_FIRST;
        end else if (WR_STB) begin
          key_d = KEY_IDLE;
        end
      end
      default: begin
        win_d = win_q - 2'd1;
        if (WR_STB || win_q == 2'd1) begin
          key_d = KEY_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      key_q <= KEY_IDLE;
      win_q <= 2'd0;
    end else begin
      key_q <= key_d;
      win_q <= win_d;
    end
  end

  // setting needs the open window; clearing is always accepted
  assign unlock_d = wr_cfg ? (WDATA[UNLOCK_BIT] && (unlock_q || unlock_allowed)) : unlock_q;

  // pointers step down on window reads and high-byte writes and hold at 00
  assign vptr_d = wr_cfg ? WDATA[PTR_LSB+1:PTR_LSB] :
                  ((rd_val || wr_val_high) && vptr_q != PTR_MINUTES_SECONDS_PAIR) ? vptr_q - 2'd1 : vptr_q;
  assign aptr_d = wr_alm_cfg ? WDATA[PTR_LSB+1:PTR_LSB] :
                  ((rd_alm || wr_alm_high) && aptr_q != PTR_MINUTES_SECONDS_PAIR) ? aptr_q - 2'd1 : aptr_q;

  // only a power-on reset returns these to zero
  always_ff @(posedge SYS_CLK) begin
    if (!POR_N) begin
      en_q <= CFG_RESET[EN_BIT];
      unlock_q <= CFG_RESET[UNLOCK_BIT];
      oe_q <= CFG_RESET[OE_BIT];
      vptr_q <= CFG_RESET[PTR_LSB+1:PTR_LSB];
      trim_q <= CFG_RESET[7:0];
    end else begin
      unlock_q <= unlock_d;
      vptr_q <= vptr_d;
      if (wr_cfg && unlock_q) begin
        en_q <= WDATA[EN_BIT];
      end
      if (wr_cfg) begin
        oe_q <= WDATA[OE_BIT];
        trim_q <= WDATA[7:0];
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      alm_en_q <= 1'b0;
      aptr_q <= PTR_MINUTES_SECONDS_PAIR;
      src_sel_q <= 1'b0;
    end else begin
      aptr_q <= aptr_d;
      if (wr_alm_cfg) begin
        alm_en_q <= WDATA[ALM_EN_BIT];
      end
      if (wr_pin) begin
        src_sel_q <= WDATA[SRC_SEL_BIT];
      end
    end
  end

  // alarm value words; pointer 11 has no storage
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_alarm
      always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
          alm_q[gi] <= 16'h0000;
        end else if (aptr_q == 2'(gi)) begin
          if (wr_alm_low) begin
            alm_q[gi][7:0] <= WDATA[7:0] & field_mask(2'(gi), 1'b0);
          end
          if (wr_alm_high) begin
            alm_q[gi][15:8] <= WDATA[7:0] & field_mask(2'(gi), 1'b1);
          end
        end
      end
    end
  endgenerate

  // time writes go through only while unlocked
  assign val_low_ok = wr_val_low && unlock_q;
  assign val_high_ok = wr_val_high && unlock_q;

  rtc_prescaler u_prescaler (
    .clk(SYS_CLK),
    .rst_n(POR_N),
    .run(en_q),
    .timebase_in(TIMEBASE_IN),
    .clear(val_low_ok && vptr_q == PTR_MINUTES_SECONDS_PAIR),
    .minute_mark(sec_v == ZERO_BCD),
    .trim(trim_q),
    .sec_tick(sec_tick),
    .half_flag(half_flag),
    .ripple(ripple)
  );

  assign day_last = month_last(mon_v, year_v);

  rtc_bcd_field #(.RESET_VALUE(ZERO_BCD), .MASK(SEC_MASK)) u_sec (
    .clk(SYS_CLK),
    .rst_n(POR_N),
    .we(val_low_ok && vptr_q == PTR_MINUTES_SECONDS_PAIR),
    .wdata(WDATA[7:0]),
    .inc(sec_tick),
    .last(SEC_LAST),
    .first(ZERO_BCD),
    .q(sec_v),
    .wrap(sec_wrap)
  );

  rtc_bcd_field #(.RESET_VALUE(ZERO_BCD), .MASK(MIN_MASK)) u_min (
    .clk(SYS_CLK),
    .rst_n(POR_N),
    .we(val_high_ok && vptr_q == PTR_MINUTES_SECONDS_PAIR),
    .wdata(WDATA[7:0]),
    .inc(sec_tick && sec_wrap),
    .last(MIN_LAST),
    .first(ZERO_BCD),
    .q(min_v),
    .wrap(min_wrap)
  );

  rtc_bcd_field #(.RESET_VALUE(ZERO_BCD), .MASK(HOUR_MASK)) u_hour (
    .clk(SYS_CLK),
    .rst_n(POR_N),
    .we(val_low_ok && vptr_q == PTR_WDHR),
    .wdata(WDATA[7:0]),
    .inc(sec_tick && sec_wrap && min_wrap),
    .last(HOUR_LAST),
    .first(ZERO_BCD),
    .q(hour_v),
    .wrap(hour_wrap)
  );

  rtc_bcd_field #(.RESET_VALUE(WDAY_RESET), .MASK(WDAY_MASK)) u_wday (
    .clk(SYS_CLK),
    .rst_n(POR_N),
    .we(val_high_ok && vptr_q == PTR_WDHR),
    .wdata(WDATA[7:0]),
    .inc(sec_tick && sec_wrap && min_wrap && hour_wrap),
    .last(WDAY_LAST),
    .first(ZERO_BCD),
    .q(wday_v),
    .wrap()
  );

  rtc_bcd_field #(.RESET_VALUE(ONE_BCD), .MASK(DAY_MASK)) u_day (
    .clk(SYS_CLK),
    .rst_n(POR_N),
    .we(val_low_ok && vptr_q == PTR_MTHDAY),
    .wdata(WDATA[7:0]),
    .inc(sec_tick && sec_wrap && min_wrap && hour_wrap),
    .last(day_last),
    .first(ONE_BCD),
    .q(day_v),
    .wrap(day_wrap)
  );

  rtc_bcd_field #(.RESET_VALUE(ONE_BCD), .MASK(MON_MASK)) u_mon (
    .clk(SYS_CLK),
    .rst_n(POR_N),
    .we(val_high_ok && vptr_q == PTR_MTHDAY),
    .wdata(WDATA[7:0]),
    .inc(sec_tick && sec_wrap && min_wrap && hour_wrap && day_wrap),
    .last(MON_LAST),
    .first(ONE_BCD),
    .q(mon_v),
    .wrap(mon_wrap)
  );

  // 99 wraps to 00: the century never changes
  rtc_bcd_field #(.RESET_VALUE(ZERO_BCD), .MASK(YEAR_MASK)) u_year (
    .clk(SYS_CLK),
    .rst_n(POR_N),
    .we(val_low_ok && vptr_q == PTR_YEAR),
    .wdata(WDATA[7:0]),
    .inc(sec_tick && sec_wrap && min_wrap && hour_wrap && day_wrap && mon_wrap),
    .last(YEAR_LAST),
    .first(ZERO_BCD),
    .q(year_v),
    .wrap()
  );

  // window read selection
  always_comb begin
    val_lo = year_v;
    val_hi = 8'h00;
    case (vptr_q)
      PTR_MINUTES_SECONDS_PAIR: begin
        val_lo = sec_v;
        val_hi = min_v;
      end
      PTR_WDHR: begin
        val_lo = hour_v;
        val_hi = wday_v;
      end
      PTR_MTHDAY: begin
        val_lo = day_v;
        val_hi = mon_v;
      end
      default: begin
        val_lo = year_v;
        val_hi = 8'h00;
      end
    endcase
  end

  assign alm_word = (aptr_q == PTR_YEAR) ? 16'h0000 : alm_q[aptr_q];

  always_comb begin
    if (ADDR == CFG_ADDR) begin
      rdata_d = {en_q, 1'b0, unlock_q, ripple, half_flag, oe_q, vptr_q, trim_q};
    end else if (ADDR == VAL_LOW_ADDR) begin
      rdata_d = {8'h00, val_lo};
    end else if (ADDR == VAL_HIGH_ADDR) begin
      rdata_d = {8'h00, val_hi};
    end else if (ADDR == ALM_CFG_ADDR) begin
      rdata_d = {alm_en_q, 5'h00, aptr_q, 8'h00};
    end else if (ADDR == ALM_LOW_ADDR) begin
      rdata_d = {8'h00, alm_word[7:0]};
    end else if (ADDR == ALM_HIGH_ADDR) begin
      rdata_d = {8'h00, alm_word[15:8]};
    end else if (ADDR == PIN_CFG_ADDR) begin
      rdata_d = {14'h0000, src_sel_q, 1'b0};
    end else begin
      rdata_d = 16'h0000;
    end
  end

  // alarm pulse: high for the whole second that matches every alarm field
  assign alarm_match = alm_en_q && {min_v, sec_v} == alm_q[0] &&
                       {wday_v, hour_v} == alm_q[1] && {mon_v, day_v} == alm_q[2];
  // seconds clock is high in the first half of each second
  assign pin_level = src_sel_q ? !half_flag : alarm_level_q;

  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      RDATA <= 16'h0000;
      alarm_level_q <= 1'b0;
      TIMEKEEPER_OUT <= 1'b0;
      TIMEKEEPER_OE <= 1'b0;
    end else begin
      RDATA <= RD_STB ? rdata_d : 16'h0000;
      alarm_level_q <= alarm_match;
      TIMEKEEPER_OUT <= oe_q && pin_level;
      TIMEKEEPER_OE <= oe_q;
    end
  end
endmodule

// *** rtl/rtc_pkg.sv ***
/*
  Shared constants for the calendar clock block: register offsets, field
  positions, reset values, BCD limits and timebase counts.
  Assumes a single 200 MHz system clock and a 32.768 kHz timebase level input.
*/
package rtc_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  // register offsets (word index on the plain register port)
  localparam logic [3:0] CFG_ADDR = 4'h0;
  localparam logic [3:0] VAL_LOW_ADDR = 4'h1;
  localparam logic [3:0] VAL_HIGH_ADDR = 4'h2;
  localparam logic [3:0] ALM_CFG_ADDR = 4'h3;
  localparam logic [3:0] ALM_LOW_ADDR = 4'h4;
  localparam logic [3:0] ALM_HIGH_ADDR = 4'h5;
  localparam logic [3:0] KEY_ADDR = 4'h6;
  localparam logic [3:0] PIN_CFG_ADDR = 4'h7;
  // calib_config_register fields
  localparam int EN_BIT = 15;
  localparam int UNLOCK_BIT = 13;
  localparam int RIPPLE_BIT = 12;
  localparam int HALF_BIT = 11;
  localparam int OE_BIT = 10;
  localparam int PTR_LSB = 8;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  // alarm_config_register and pin configuration fields
  localparam int ALM_EN_BIT = 15;
  localparam int SRC_SEL_BIT = 1;
  // unlock sequence
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;
  localparam logic [1:0] UNLOCK_WINDOW_CYC = 2'd2;
  // window pointer values
  localparam logic [1:0] PTR_MINUTES_SECONDS_PAIR = 2'h0;
  localparam logic [1:0] PTR_WDHR = 2'h1;
  localparam logic [1:0] PTR_MTHDAY = 2'h2;
  localparam logic [1:0] PTR_YEAR = 2'h3;
  // implemented bits of each BCD field
  localparam logic [7:0] SEC_MASK = 8'h7f;
  localparam logic [7:0] MIN_MASK = 8'h7f;
  localparam logic [7:0] HOUR_MASK = 8'h3f;
  localparam logic [7:0] WDAY_MASK = 8'h07;
  localparam logic [7:0] DAY_MASK = 8'h3f;
  localparam logic [7:0] MON_MASK = 8'h1f;
  localparam logic [7:0] YEAR_MASK = 8'hff;
  // BCD limits
  localparam logic [7:0] ZERO_BCD = 8'h00;
  localparam logic [7:0] SEC_LAST = 8'h59;
  localparam logic [7:0] MIN_LAST = 8'h59;
  localparam logic [7:0] HOUR_LAST = 8'h23;
  localparam logic [7:0] WDAY_LAST = 8'h06;
  localparam logic [7:0] MON_LAST = 8'h12;
  localparam logic [7:0] YEAR_LAST = 8'h99;
  localparam logic [7:0] ONE_BCD = 8'h01;
  localparam logic [7:0] FEB_BCD = 8'h02;
  localparam logic [7:0] DAYS_28 = 8'h28;
  localparam logic [7:0] DAYS_29 = 8'h29;
  localparam logic [7:0] DAYS_30 = 8'h30;
  localparam logic [7:0] DAYS_31 = 8'h31;
  // power-on time: 2000-01-01 00:00:00, weekday code 6
  localparam logic [7:0] WDAY_RESET = 8'h06;
  // timebase
  localparam int TIMEBASE_HZ = 32768;
  localparam logic [16:0] SEC_LAST_TICK = 17'(TIMEBASE_HZ - 1);
  localparam logic [15:0] HALF_TICKS = 16'(TIMEBASE_HZ / 2);
  localparam int TRIM_SHIFT = 2;
  localparam logic [16:0] RIPPLE_TICKS = 17'd32;
  typedef enum logic [1:0] {KEY_IDLE, KEY_GOT_FIRST, KEY_OPEN} key_state_type;
endpackage

// *** rtl/rtc_bcd_field.sv ***
/*
  One BCD time or calendar field with load, increment and wrap.
  Assumes the caller cascades the wrap flag into the next field.
*/
module rtc_bcd_field #(
  parameter logic [7:0] RESET_VALUE = 8'h00,
  parameter logic [7:0] MASK = 8'hff
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic we,
  input wire logic [7:0] wdata,
  input wire logic inc,
  input wire logic [7:0] last,
  input wire logic [7:0] first,
  output logic [7:0] q,
  output logic wrap
);
  logic [7:0] q_q;
  logic [7:0] q_d;

  assign wrap = (q_q == last);
  assign q = q_q;
  // decimal carry keeps each nibble in 0..9
  assign q_d = wrap ? first : (q_q[3:0] == 4'h9) ? {q_q[7:4] + 4'h1, 4'h0} : q_q + 8'h01;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q_q <= RESET_VALUE;
    end else if (we) begin
      q_q <= wdata & MASK;
    end else if (inc) begin
      q_q <= q_d;
    end
  end
endmodule

// *** rtl/rtc_prescaler.sv ***
/*
  Divides the 32.768 kHz timebase into seconds, with per-minute trim,
  half-second flag and a ripple warning near each second boundary.
  Assumes timebase_in is a level already synchronous to clk.
*/
module rtc_prescaler (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic timebase_in,
  input wire logic clear,
  input wire logic minute_mark,
  input wire logic [7:0] trim,
  output logic sec_tick,
  output logic half_flag,
  output logic ripple
);
  import rtc_pkg::*;
  logic tb_prev_q;
  logic [15:0] cnt_q;
  logic tick;
  logic [16:0] adj;
  logic [16:0] term;
  logic at_end;

  assign tick = run && timebase_in && !tb_prev_q;
  assign adj = minute_mark ? ({{9{trim[7]}}, trim} << TRIM_SHIFT) : 17'h00000;
  // a positive trim shortens the marked second, a negative one stretches it
  assign term = SEC_LAST_TICK - adj;
  assign at_end = ({1'b0, cnt_q} >= term);
  assign sec_tick = tick && at_end;
  assign half_flag = (cnt_q >= HALF_TICKS);
  assign ripple = ({1'b0, cnt_q} + RIPPLE_TICKS >= term);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tb_prev_q <= 1'b0;
      cnt_q <= 16'h0000;
    end else begin
      tb_prev_q <= timebase_in;
      if (clear) begin
        cnt_q <= 16'h0000;
      end else if (tick) begin
        cnt_q <= at_end ? 16'h0000 : cnt_q + 16'h0001;
      end
    end
  end
endmodule

// *** bench/rtc_calendar_chk.sv ***
/*
  Port checker for the calendar clock top.
  Assumes it is bound to rtc_calendar and sees only that module's ports.
*/
module rtc_calendar_chk
  import rtc_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  input wire logic POR_N,
  input wire logic TIMEBASE_IN,
  input wire logic [rtc_pkg::ADDR_W-1:0] ADDR,
  input wire logic [rtc_pkg::DATA_W-1:0] WDATA,
  input wire logic WR_STB,
  input wire logic RD_STB,
  input wire logic [rtc_pkg::DATA_W-1:0] RDATA,
  input wire logic TIMEKEEPER_OUT,
  input wire logic TIMEKEEPER_OE
);
  wire logic rd_cfg = RD_STB && ADDR == CFG_ADDR;
  wire logic rd_alm = RD_STB && ADDR == ALM_CFG_ADDR;
  wire logic [1:0] ptr_now = RDATA[9:8];
  wire logic en_now = RDATA[EN_BIT];
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N || !POR_N);
  a_rdata_idle: assert property (!RD_STB |=> RDATA == 16'h0000)
    else $error("read data not idle");
  a_key_reads_zero: assert property (RD_STB && ADDR == KEY_ADDR |=> RDATA == 16'h0000)
    else $error("key register read not zero");
  a_pin_quiet: assert property (!TIMEKEEPER_OE |-> !TIMEKEEPER_OUT)
    else $error("pin data while not driven");
  a_oe_matches_cfg: assert property (rd_cfg |=> RDATA[OE_BIT] == TIMEKEEPER_OE)
    else $error("pin enable differs from config bit");
  // a seconds write only clears the flag when it really lands
  a_half_cleared: assert property (WR_STB && ADDR == VAL_LOW_ADDR ##2 rd_cfg |=>
    !RDATA[HALF_BIT] || !RDATA[UNLOCK_BIT] || ptr_now != PTR_MINUTES_SECONDS_PAIR)
    else $error("half flag set after seconds write");
  a_val_ptr_step: assert property (rd_cfg ##2 RD_STB && ADDR == VAL_LOW_ADDR ##2 rd_cfg |=>
    ptr_now == ($past(ptr_now, 4) == 2'h0 ? 2'h0 : $past(ptr_now, 4) - 2'h1))
    else $error("value pointer did not step on read");
  a_alm_ptr_step: assert property (rd_alm ##2 RD_STB && ADDR == ALM_LOW_ADDR ##2 rd_alm |=>
    ptr_now == ($past(ptr_now, 4) == 2'h0 ? 2'h0 : $past(ptr_now, 4) - 2'h1))
    else $error("alarm pointer did not step on read");
  a_lock_keeps_en: assert property (rd_cfg ##1 !RDATA[UNLOCK_BIT] ##1 WR_STB && ADDR == CFG_ADDR
    ##1 rd_cfg |=> en_now == $past(en_now, 3))
    else $error("enable changed while locked");
endmodule

// *** bench/tb_rtc_calendar.sv ***
/*
  Self-checking bench for the calendar clock: config, unlock keys, pointer
  windows, half-second flag, rollover and both resets.
  Assumes rtc_pkg, rtc_calendar and the checker are compiled before it.
*/
module tb_rtc_calendar;
  timeunit 1ns;
  timeprecision 1ps;
  import rtc_pkg::*;
  logic sys_clk, reset_n, por_n, timebase_in, wr_stb, rd_stb, en_v, unl_v, oe_v;
  logic [3:0] addr, cf_a, lo_a, hi_a;
  logic [15:0] wdata, rd_q;
  wire logic [15:0] rdata;
  wire logic tk_out, tk_oe;
  logic [7:0] trim_v, s8, m8;
  logic [31:0] lfsr;
  int compares, n_fail, cyc_n, t0;
  logic [1:0] ptr_exp [5] = '{2'h2, 2'h1, 2'h1, 2'h0, 2'h0};
  logic [7:0] set_hi [4] = '{8'h59, 8'h06, 8'h12, 8'h00};
  logic [7:0] set_lo [4] = '{8'h59, 8'h23, 8'h31, 8'h99};
  logic [7:0] new_hi [4] = '{ZERO_BCD, ZERO_BCD, ONE_BCD, ZERO_BCD};
  logic [7:0] new_lo [4] = '{ZERO_BCD, ZERO_BCD, ONE_BCD, ZERO_BCD};
  rtc_calendar i_dut (.SYS_CLK(sys_clk), .RESET_N(reset_n), .POR_N(por_n), .TIMEBASE_IN(timebase_in),
    .ADDR(addr), .WDATA(wdata), .WR_STB(wr_stb), .RD_STB(rd_stb), .RDATA(rdata),
    .TIMEKEEPER_OUT(tk_out), .TIMEKEEPER_OE(tk_oe));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // timebase pulse every second cycle: one second is 65536 cycles
  always @(posedge sys_clk) begin
    cyc_n <= cyc_n + 1;
    timebase_in <= ~timebase_in;
  end
  function automatic logic [31:0] step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] bcd(input int n);
    return 8'((n / 10) * 16 + n % 10);
  endfunction
  function automatic logic [15:0] mk(input logic [1:0] p);
    return {en_v, 1'b0, unl_v, 2'b00, oe_v, p, trim_v};
  endfunction
  // called right after a rising edge; rd_q is what the slave showed before the next one
  task automatic cyc(input logic w, input logic r, input logic [3:0] a, input logic [15:0] d);
    wr_stb <= w;
    rd_stb <= r;
    addr <= a;
    wdata <= d;
    @(posedge sys_clk);
    rd_q = rdata;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    cyc(1'b1, 1'b0, a, d);
  endtask
  task automatic setp(input logic [1:0] p);
    wr(CFG_ADDR, mk(p));
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rdchk(input string what, input logic [3:0] a, input logic [15:0] m, input logic [15:0] exp);
    cyc(1'b0, 1'b1, a, 16'h0000);
    cyc(1'b0, 1'b0, a, 16'h0000);
    check(what, rd_q & m, exp);
  endtask
  task automatic wait_for(input int t);
    while (cyc_n < t) cyc(1'b0, 1'b0, CFG_ADDR, 16'h0000);
  endtask
  task automatic unlock(input logic [7:0] k1, input logic [7:0] k2, input int gap, input logic exp);
    wr(KEY_ADDR, {8'h00, k1});
    wr(KEY_ADDR, {8'h00, k2});
    repeat (gap) cyc(1'b0, 1'b0, CFG_ADDR, 16'h0000);
    unl_v = 1'b1;
    setp(PTR_MINUTES_SECONDS_PAIR);
    unl_v = exp;
    rdchk("unlock", CFG_ADDR, 16'h2000, {2'b00, exp, 13'h0});
  endtask
  // each read needs its own pointer load, since any window read above 00 moves it
  task automatic chk_time(input logic [7:0] hi [4], input logic [7:0] lo [4]);
    for (int p = 3; p >= 0; p--) begin
      setp(2'(p));
      rdchk("time high", VAL_HIGH_ADDR, 16'h00ff, {8'h00, hi[p]});
      setp(2'(p));
      rdchk("time low", VAL_LOW_ADDR, 16'h00ff, {8'h00, lo[p]});
    end
  endtask
  task automatic results;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (106000) @(posedge sys_clk);
    n_fail++;
    results();
  end
  initial begin
    {reset_n, por_n, timebase_in, wr_stb, rd_stb, en_v, unl_v, oe_v} = 8'h00;
    addr = 4'h0;
    wdata = 16'h0000;
    trim_v = 8'h00;
    lfsr = 32'h80783a3c;
    cyc_n = 0;
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    por_n <= 1'b1;
    rdchk("config reset", CFG_ADDR, 16'hffff, CFG_RESET);
    en_v = 1'b1;
    setp(PTR_MINUTES_SECONDS_PAIR);
    en_v = 1'b0;
    rdchk("locked enable", CFG_ADDR, 16'h8000, 16'h0000);
    rdchk("unmapped", 4'hf, 16'hffff, 16'h0000);
    rdchk("key read", KEY_ADDR, 16'hffff, 16'h0000);
    unlock(KEY_SECOND, KEY_FIRST, 0, 1'b0);
    unlock(KEY_FIRST, KEY_SECOND, 2, 1'b0);
    unlock(KEY_FIRST, KEY_SECOND, 1, 1'b1);
    {en_v, oe_v} = 2'b11;
    lfsr = step(lfsr);
    trim_v = lfsr[7:0];
    setp(PTR_MINUTES_SECONDS_PAIR);
    rdchk("config fields", CFG_ADDR, 16'he7ff, mk(PTR_MINUTES_SECONDS_PAIR));
    wr(PIN_CFG_ADDR, 16'h0002);
    rdchk("pin config", PIN_CFG_ADDR, 16'h0002, 16'h0002);
    $display("config tests done");
    for (int i = 0; i < 2; i++) begin
      cf_a = i != 0 ? ALM_CFG_ADDR : CFG_ADDR;
      lo_a = i != 0 ? ALM_LOW_ADDR : VAL_LOW_ADDR;
      hi_a = i != 0 ? ALM_HIGH_ADDR : VAL_HIGH_ADDR;
      wr(cf_a, i != 0 ? 16'h0300 : mk(PTR_YEAR));
      for (int s = 0; s < 5; s++) begin
        cyc(s > 1, s < 2, (s == 1 || s == 2) ? lo_a : hi_a, 16'h0000);
        if (s < 2) cyc(1'b0, 1'b0, CFG_ADDR, 16'h0000);
        rdchk("pointer", cf_a, 16'h0300, {6'h00, ptr_exp[s], 8'h00});
      end
    end
    repeat (3) begin
      lfsr = step(lfsr);
      s8 = bcd(int'(lfsr[15:0] % 16'd60));
      m8 = bcd(int'(lfsr[31:16] % 16'd60));
      wr(ALM_LOW_ADDR, {8'h00, s8});
      wr(ALM_HIGH_ADDR, {8'h00, m8});
      rdchk("alarm seconds", ALM_LOW_ADDR, 16'h00ff, {8'h00, s8});
      rdchk("alarm minutes", ALM_HIGH_ADDR, 16'h00ff, {8'h00, m8});
    end
    $display("window tests done");
    for (int p = 3; p >= 0; p--) begin
      setp(2'(p));
      wr(VAL_LOW_ADDR, {8'h00, set_lo[p]});
      wr(VAL_HIGH_ADDR, {8'h00, set_hi[p]});
    end
    t0 = cyc_n;
    chk_time(set_hi, set_lo);
    wait_for(t0 + 16000);
    rdchk("first half", CFG_ADDR, 16'h1800, 16'h0000);
    check("pin level", {15'h0, tk_out}, 16'h0001);
    wait_for(t0 + 33200);
    rdchk("second half", CFG_ADDR, 16'h1800, 16'h0800);
    check("pin level", {15'h0, tk_out}, 16'h0000);
    setp(PTR_MINUTES_SECONDS_PAIR);
    wr(VAL_LOW_ADDR, {8'h00, set_lo[0]});
    wr(VAL_HIGH_ADDR, {8'h00, set_hi[0]});
    t0 = cyc_n;
    rdchk("half cleared", CFG_ADDR, 16'h0800, 16'h0000);
    wait_for(t0 + 65500);
    rdchk("ripple", CFG_ADDR, 16'h1000, 16'h1000);
    // while the warning shows, a value counts only once two reads agree
    rdchk("reread", VAL_LOW_ADDR, 16'h00ff, {8'h00, set_lo[0]});
    s8 = rd_q[7:0];
    rdchk("reread match", VAL_LOW_ADDR, 16'h00ff, {8'h00, s8});
    wait_for(t0 + 65700);
    chk_time(new_hi, new_lo);
    unl_v = 1'b0;
    setp(PTR_MINUTES_SECONDS_PAIR);
    lfsr = step(lfsr);
    wr(VAL_LOW_ADDR, {8'h00, bcd(1 + int'(lfsr[15:0] % 16'd59))});
    rdchk("locked write", VAL_LOW_ADDR, 16'h00ff, {8'h00, ZERO_BCD});
    rdchk("lock clear", CFG_ADDR, 16'h2000, 16'h0000);
    en_v = 1'b0;
    setp(PTR_MINUTES_SECONDS_PAIR);
    en_v = 1'b1;
    rdchk("enable kept", CFG_ADDR, 16'h8000, 16'h8000);
    $display("time tests done");
    reset_n <= 1'b0;
    cyc(1'b0, 1'b0, CFG_ADDR, 16'h0000);
    cyc(1'b0, 1'b0, CFG_ADDR, 16'h0000);
    check("pin off in reset", {15'h0, tk_oe}, 16'h0000);
    reset_n <= 1'b1;
    rdchk("config kept", CFG_ADDR, 16'he7ff, mk(PTR_MINUTES_SECONDS_PAIR));
    por_n <= 1'b0;
    cyc(1'b0, 1'b0, CFG_ADDR, 16'h0000);
    por_n <= 1'b1;
    rdchk("config cleared", CFG_ADDR, 16'hffff, CFG_RESET);
    $display("reset tests done");
    results();
  end
endmodule
bind rtc_calendar rtc_calendar_chk i_chk (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .POR_N(POR_N),
  .TIMEBASE_IN(TIMEBASE_IN), .ADDR(ADDR), .WDATA(WDATA), .WR_STB(WR_STB), .RD_STB(RD_STB),
  .RDATA(RDATA), .TIMEKEEPER_OUT(TIMEKEEPER_OUT), .TIMEKEEPER_OE(TIMEKEEPER_OE));
